// [common/flash_opt_pkg.sv]
package flash_opt_pkg;
  // --------------------------------------------------------------
  // Address map of the data space window
  // --------------------------------------------------------------
  localparam logic [15:0] INFO_FIRST = 16'hfe00;
  localparam logic [15:0] INFO_LAST = 16'hfe7f;
  localparam logic [6:0] INFO_USER_LAST = 7'h3f;
  localparam int PAGE_INFO_BIT = 7;
  localparam logic [2:0] HIGH_SECTOR = 3'h7;
  // --------------------------------------------------------------
  // Register offsets and reset values
  // --------------------------------------------------------------
  localparam logic [3:0] REG_FREQ_HI = 4'h0;
  localparam logic [3:0] REG_FREQ_LO = 4'h1;
  localparam logic [3:0] REG_PAGE = 4'h2;
  localparam logic [3:0] REG_PAGE_CHK = 4'h3;
  localparam logic [3:0] REG_SECT = 4'h4;
  localparam logic [3:0] REG_PADDR = 4'h5;
  localparam logic [3:0] REG_PDATA = 4'h6;
  localparam logic [3:0] REG_CTL = 4'h7;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] OPT_RST = 8'hff;
  // Status bit positions
  localparam int STAT_BUSY = 7;
  localparam int STAT_OPEN = 6;
  localparam int STAT_PMATCH = 5;
  localparam int STAT_INFO = 4;
  localparam int STAT_ERR = 3;
  // Control codes
  localparam logic [7:0] UNLOCK_KEY1 = 8'h73;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h8c;
  localparam logic [7:0] CMD_PROG = 8'h5a;
  localparam logic [7:0] CMD_ERASE = 8'h95;
  // --------------------------------------------------------------
  // Option bytes in program memory and their fields
  // --------------------------------------------------------------
  localparam logic [15:0] OPT_ADDR0 = 16'h0000;
  localparam logic [15:0] OPT_ADDR1 = 16'h0001;
  localparam int OPT_WDT_IRQ_BIT = 7;
  localparam int OPT_WDT_ON_BIT = 6;
  localparam int OPT_BO_STOP_BIT = 5;
  localparam int OPT_OSC_LSB = 3;
  localparam int OPT_RP_BIT = 2;
  localparam int OPT_HSWP_BIT = 1;
  localparam int OPT_WP_BIT = 0;
  localparam int OPT_IPO_LSB = 3;
  localparam int OPT_BO_TRIM_LSB = 0;
  // --------------------------------------------------------------
  // Timing, scaled at run time by the frequency value in kHz
  // --------------------------------------------------------------
  localparam logic [19:0] PROG_TIME_US = 20'd20;
  localparam logic [19:0] ERASE_TIME_MS = 20'd10;
  localparam logic [19:0] US_PER_MS = 20'd1000;
  localparam logic [19:0] UNIT_DIV = 20'd1;
  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [1:0] {LK_LOCKED, LK_KEY1, LK_OPEN} lock_t;
  typedef enum logic [1:0] {WP_NONE, WP_HIGH, WP_ALL} wp_level_t;
  typedef enum logic [2:0] {LD_REQ0, LD_WAIT0, LD_CAP0, LD_REQ1, LD_WAIT1, LD_CAP1, LD_RUN} load_t;
  // Programmed option bits read as zero
  function automatic wp_level_t wp_decode(input logic wp, input logic hswp);
    if (!wp) wp_decode = WP_ALL;
    else if (!hswp) wp_decode = WP_HIGH;
    else wp_decode = WP_NONE;
  endfunction
endpackage

// [hdl/pulse_timer.sv]
module pulse_timer import flash_opt_pkg::*; #(
  parameter logic [19:0] ERASE_MS = ERASE_TIME_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Launch
  input wire logic start,
  input wire logic is_erase,
  input wire logic [15:0] freq_khz,
  // State
  output logic busy
);
  // Cycles = kHz * time / divider, rounded up, never below one
  function automatic logic [23:0] scale(input logic [15:0] khz, input logic [19:0] num,
                                        input logic [19:0] den);
    logic [39:0] p;
    p = ({24'h0, khz} * {20'h0, num} + {20'h0, den} - 40'h1) / {20'h0, den};
    scale = (p[23:0] == 24'h0) ? 24'h1 : p[23:0];
  endfunction

  logic [23:0] cnt_q;
  logic [23:0] load_w;

  // Pulse length follows the clock rate so its duration stays fixed
  assign load_w = is_erase ? scale(freq_khz, ERASE_MS, UNIT_DIV) : scale(freq_khz, PROG_TIME_US, US_PER_MS);
  assign busy = (cnt_q != 24'h0);

  // Down counter; a start while busy is ignored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cnt_q <= 24'h0;
    else if (start && !busy) cnt_q <= load_w;
    else if (busy) cnt_q <= cnt_q - 24'h1;
  end

  property p_load;
    @(posedge clk) disable iff (!rst_b) (start && !busy) |=> (cnt_q == $past(load_w));
  endproperty
  a_load: assert property (p_load) else $error("pulse length not loaded");
  property p_count;
    @(posedge clk) disable iff (!rst_b) (busy && !start) |=> (cnt_q == $past(cnt_q) - 24'h1);
  endproperty
  a_count: assert property (p_count) else $error("pulse counter skipped");
endmodule

// [hdl/opt_loader.sv]
module opt_loader import flash_opt_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Stop-mode recovery pin, asynchronous
  input wire logic stop_recover,
  // Flash read path
  input wire logic [7:0] fl_rdata,
  output logic ld_rd,
  output logic ld_sel,
  // Loaded configuration
  output logic hold,
  output logic [7:0] opt0_q,
  output logic [7:0] opt1_q
);
  load_t state_q;
  load_t state_d;
  logic sync0_q;
  logic sync1_q;
  logic prev_q;
  logic recover;

  // Recovery pulse from the second sync stage only
  assign recover = sync1_q && !prev_q;
  assign ld_rd = (state_q == LD_REQ0) || (state_q == LD_REQ1);
  assign ld_sel = (state_q == LD_REQ1);
  // CPU stays in reset until both bytes are in
  assign hold = (state_q != LD_RUN);

  // Load sequence, restarted by any reset
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      LD_REQ0: state_d = LD_WAIT0;
      LD_WAIT0: state_d = LD_CAP0;
      LD_CAP0: state_d = LD_REQ1;
      LD_REQ1: state_d = LD_WAIT1;
      LD_WAIT1: state_d = LD_CAP1;
      LD_CAP1: state_d = LD_RUN;
      LD_RUN: state_d = LD_RUN;
      default: state_d = LD_REQ0;
    endcase
    if (recover) state_d = LD_REQ0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= LD_REQ0;
      sync0_q <= 1'b0;
      sync1_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sync0_q <= stop_recover;
      sync1_q <= sync0_q;
      prev_q <= sync1_q;
    end
  end

  // Option bytes change only during a load
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      opt0_q <= OPT_RST;
      opt1_q <= OPT_RST;
    end else begin
      if (state_q == LD_CAP0) opt0_q <= fl_rdata;
      if (state_q == LD_CAP1) opt1_q <= fl_rdata;
    end
  end

  property p_restart;
    @(posedge clk) disable iff (!rst_b) recover |=> (state_q == LD_REQ0) ##5 hold ##1 !hold;
  endproperty
  a_restart: assert property (p_restart) else $error("reload not taken on recovery");
  property p_stable;
    @(posedge clk) disable iff (!rst_b) (!hold && !$past(hold)) |-> ($stable(opt0_q) && $stable(opt1_q));
  endproperty
  a_stable: assert property (p_stable) else $error("options changed outside load");
endmodule

// [hdl/flash_timing_protect_options.sv]
// Contract
// - Information area maps onto data addresses FE00H through FE7FH.
// - Information area reachable only while page select bit 7 is one.
// - Area holds trim and calibration; only the lower part is user-open.
// - High and low frequency bytes form one 16-bit timing value.
// - Read-protect option stops the debugger reading flash code.
// - Two write-protect options decode into three protection levels.
// - Protection joins options, lock, redundant page select, sector bits.
// - Every reset or stop recovery reloads options from flash.
// - Options are loaded before the processor leaves reset.
// - Changed option bits act only after a later reset.
// - Option configuration registers are invisible to software.
// - Options pick watchdog interrupt or reset, and run at reset.
// - Options pick oscillator mode and brownout behaviour in stop.
// - Options deliver oscillator and brownout threshold trim.
// - Information area lies in data space; user writes there blocked.
module flash_timing_protect_options import flash_opt_pkg::*; #(
  parameter logic [19:0] ERASE_MS = ERASE_TIME_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // CPU data space
  input wire logic [15:0] data_addr,
  input wire logic data_rd,
  input wire logic data_wr,
  output logic info_sel,
  output logic data_wr_block,
  // Debugger read path
  input wire logic dbg_rd_req,
  output logic dbg_rd_grant,
  // Flash array
  input wire logic [7:0] fl_rdata,
  output logic fl_rd,
  output logic [15:0] fl_addr,
  output logic fl_info,
  output logic [7:0] fl_wdata,
  output logic fl_prog,
  output logic fl_erase,
  // Reset sequencing
  input wire logic stop_recover,
  output logic cpu_rst_hold,
  // Loaded configuration
  output logic wdt_irq_mode,
  output logic wdt_run_at_reset,
  output logic bo_on_in_stop,
  output logic [1:0] osc_mode,
  output logic [4:0] ipo_trim,
  output logic [2:0] bo_trim
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] freq_hi_q;
  logic [7:0] freq_lo_q;
  logic [7:0] page_q;
  logic [7:0] page_chk_q;
  logic [7:0] sect_q;
  logic [7:0] paddr_q;
  logic [7:0] pdata_q;
  lock_t unlk_q;
  lock_t unlk_d;
  logic err_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_mux;
  logic [7:0] stat_w;
  logic fl_rd_q;
  logic [15:0] fl_addr_q;
  logic fl_info_q;
  logic [7:0] fl_wdata_q;
  logic op_erase_q;
  logic [15:0] flash_timing_freq_value;
  logic busy;
  logic op_go;
  logic refuse;
  logic ld_rd;
  logic ld_sel;
  logic hold;
  logic [7:0] opt0;
  logic [7:0] opt1;
  logic read_protect_option;
  logic write_protect_option;
  logic high_sector_write_protect_option;
  wp_level_t wp_lvl;
  logic wr_hi;
  logic wr_lo;
  logic wr_page;
  logic wr_chk;
  logic wr_sect;
  logic wr_paddr;
  logic wr_pdata;
  logic wr_ctl;
  logic wr_stat;
  logic in_info;
  logic info_en;
  logic info_user;
  logic page_match;
  logic [2:0] sector;
  logic sect_prot;
  logic wp_ok;
  logic op_ok;
  logic is_cmd;
  logic cmd_erase;

  // ----------------------------------------------------------------
  // Option load at reset
  // ----------------------------------------------------------------
  // The CPU is released only when both bytes are captured
  opt_loader u_loader (
    .clk(clk),
    .rst_b(rst_b),
    .stop_recover(stop_recover),
    .fl_rdata(fl_rdata),
    .ld_rd(ld_rd),
    .ld_sel(ld_sel),
    .hold(hold),
    .opt0_q(opt0),
    .opt1_q(opt1)
  );
  assign cpu_rst_hold = hold;

  // Decoded option fields; the option bytes themselves are never mapped
  assign read_protect_option = !opt0[OPT_RP_BIT];
  assign write_protect_option = opt0[OPT_WP_BIT];
  assign high_sector_write_protect_option = opt0[OPT_HSWP_BIT];
  assign wp_lvl = wp_decode(write_protect_option, high_sector_write_protect_option);
  assign wdt_irq_mode = opt0[OPT_WDT_IRQ_BIT];
  assign wdt_run_at_reset = !opt0[OPT_WDT_ON_BIT];
  assign bo_on_in_stop = opt0[OPT_BO_STOP_BIT];
  assign osc_mode = opt0[OPT_OSC_LSB +: 2];
  assign ipo_trim = opt1[OPT_IPO_LSB +: 5];
  assign bo_trim = opt1[OPT_BO_TRIM_LSB +: 3];

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // Address compare for each writable register
  assign wr_hi = reg_wr && (reg_addr == REG_FREQ_HI);
  assign wr_lo = reg_wr && (reg_addr == REG_FREQ_LO);
  assign wr_page = reg_wr && (reg_addr == REG_PAGE);
  assign wr_chk = reg_wr && (reg_addr == REG_PAGE_CHK);
  assign wr_sect = reg_wr && (reg_addr == REG_SECT);
  assign wr_paddr = reg_wr && (reg_addr == REG_PADDR);
  assign wr_pdata = reg_wr && (reg_addr == REG_PDATA);
  assign wr_ctl = reg_wr && (reg_addr == REG_CTL);
  assign wr_stat = reg_wr && (reg_addr == REG_STAT);

  // Timing value governs every program and erase pulse
  assign flash_timing_freq_value = {freq_hi_q, freq_lo_q};

  // ----------------------------------------------------------------
  // Information area window
  // ----------------------------------------------------------------
  // Range check plus the enable bit of the page select register
  assign in_info = (data_addr >= INFO_FIRST) && (data_addr <= INFO_LAST);
  assign info_en = page_q[PAGE_INFO_BIT];
  // Factory trim half stays hidden from user code
  assign info_user = (data_addr[6:0] <= INFO_USER_LAST);
  assign info_sel = in_info && info_en && info_user && (data_rd || data_wr);
  // Data writes never reach the window; only the controller programs it
  assign data_wr_block = data_wr && in_info;

  // ----------------------------------------------------------------
  // Debugger gating
  // ----------------------------------------------------------------
  assign dbg_rd_grant = dbg_rd_req && !read_protect_option;

  // ----------------------------------------------------------------
  // Protection checks
  // ----------------------------------------------------------------
  // Page select must be written twice with the same value
  assign page_match = (page_q == page_chk_q);
  assign sector = page_q[6:4];
  // Sector bits guard main memory only, not the information page
  assign sect_prot = !info_en && sect_q[sector];
  assign wp_ok = info_en || (wp_lvl == WP_NONE) || ((wp_lvl == WP_HIGH) && (sector != HIGH_SECTOR));
  assign is_cmd = (reg_wdata == CMD_PROG) || (reg_wdata == CMD_ERASE);
  assign cmd_erase = (reg_wdata == CMD_ERASE);
  assign op_ok = page_match && !busy && !sect_prot && wp_ok && !hold;

  // Unlock sequence; any command or wrong key relocks
  always_comb begin
    unlk_d = unlk_q;
    op_go = 1'b0;
    refuse = 1'b0;
    if (wr_ctl) begin
      unique case (unlk_q)
        LK_LOCKED: begin
          if (reg_wdata == UNLOCK_KEY1) unlk_d = LK_KEY1;
          else refuse = 1'b1;
        end
        LK_KEY1: begin
          if (reg_wdata == UNLOCK_KEY2) begin
            unlk_d = LK_OPEN;
          end else begin
            unlk_d = LK_LOCKED;
            refuse = 1'b1;
          end
        end
        LK_OPEN: begin
          unlk_d = LK_LOCKED;
          if (is_cmd && op_ok) op_go = 1'b1;
          else refuse = 1'b1;
        end
        default: unlk_d = LK_LOCKED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pulse timing
  // ----------------------------------------------------------------
  pulse_timer #(
    .ERASE_MS(ERASE_MS)
  ) u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .start(op_go),
    .is_erase(cmd_erase),
    .freq_khz(flash_timing_freq_value),
    .busy(busy)
  );
  assign fl_prog = busy && !op_erase_q;
  assign fl_erase = busy && op_erase_q;

  // ----------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------
  // Frequency and page fields are frozen while a pulse runs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_hi_q <= BYTE_RST;
      freq_lo_q <= BYTE_RST;
      page_q <= BYTE_RST;
      page_chk_q <= BYTE_RST;
      paddr_q <= BYTE_RST;
      pdata_q <= BYTE_RST;
    end else if (!busy) begin
      if (wr_hi) freq_hi_q <= reg_wdata;
      if (wr_lo) freq_lo_q <= reg_wdata;
      if (wr_page) page_q <= reg_wdata;
      if (wr_chk) page_chk_q <= reg_wdata;
      if (wr_paddr) paddr_q <= reg_wdata;
      if (wr_pdata) pdata_q <= reg_wdata;
    end
  end

  // Sector bits only set; clearing needs a reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sect_q <= BYTE_RST;
    else if (wr_sect) sect_q <= sect_q | reg_wdata;
  end

  // Lock stage and sticky refusal flag; a new refusal beats the clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unlk_q <= LK_LOCKED;
      err_q <= 1'b0;
    end else begin
      unlk_q <= unlk_d;
      err_q <= refuse || (err_q && !wr_stat);
    end
  end

  // ----------------------------------------------------------------
  // Flash array port
  // ----------------------------------------------------------------
  // Loader reads take the port while the CPU is held
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fl_rd_q <= 1'b0;
      fl_addr_q <= 16'h0000;
      fl_info_q <= 1'b0;
      fl_wdata_q <= BYTE_RST;
      op_erase_q <= 1'b0;
    end else begin
      fl_rd_q <= ld_rd;
      if (ld_rd) begin
        fl_addr_q <= ld_sel ? OPT_ADDR1 : OPT_ADDR0;
        fl_info_q <= 1'b0;
      end else if (op_go) begin
        fl_addr_q <= {2'b00, page_q[6:0], cmd_erase ? 7'h00 : paddr_q[6:0]};
        fl_info_q <= info_en;
        fl_wdata_q <= pdata_q;
        op_erase_q <= cmd_erase;
      end
    end
  end
  assign fl_rd = fl_rd_q;
  assign fl_addr = fl_addr_q;
  assign fl_info = fl_info_q;
  assign fl_wdata = fl_wdata_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Status shows block state only
  always_comb begin
    stat_w = 8'h00;
    stat_w[STAT_BUSY] = busy;
    stat_w[STAT_OPEN] = (unlk_q == LK_OPEN);
    stat_w[STAT_PMATCH] = page_match;
    stat_w[STAT_INFO] = info_en;
    stat_w[STAT_ERR] = err_q;
  end

  // No offset reaches the option registers; unmapped reads give zero
  always_comb begin
    unique case (reg_addr)
      REG_FREQ_HI: rd_mux = freq_hi_q;
      REG_FREQ_LO: rd_mux = freq_lo_q;
      REG_PAGE: rd_mux = page_q;
      REG_PAGE_CHK: rd_mux = page_chk_q;
      REG_SECT: rd_mux = sect_q;
      REG_PADDR: rd_mux = paddr_q;
      REG_PDATA: rd_mux = pdata_q;
      REG_STAT: rd_mux = stat_w;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data stands for one cycle only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rdata_q <= 8'h00;
    else rdata_q <= reg_rd ? rd_mux : 8'h00;
  end
  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_info_range;
    @(posedge clk) disable iff (!rst_b)
      info_sel |-> (data_addr[15:7] == INFO_FIRST[15:7]) && page_q[PAGE_INFO_BIT];
  endproperty
  a_info_range: assert property (p_info_range) else $error("window open outside range");
  property p_info_user;
    @(posedge clk) disable iff (!rst_b) info_sel |-> !data_addr[6];
  endproperty
  a_info_user: assert property (p_info_user) else $error("trim half exposed");
  property p_wr_block;
    @(posedge clk) disable iff (!rst_b) (data_wr && in_info) |-> data_wr_block;
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("window write not blocked");
  property p_dbg;
    @(posedge clk) disable iff (!rst_b) !opt0[OPT_RP_BIT] |-> !dbg_rd_grant;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debugger read despite protection");
  property p_wp_all;
    @(posedge clk) disable iff (!rst_b) (op_go && !opt0[OPT_WP_BIT]) |-> page_q[PAGE_INFO_BIT];
  endproperty
  a_wp_all: assert property (p_wp_all) else $error("write to fully protected memory");
  property p_go;
    @(posedge clk) disable iff (!rst_b)
      op_go |-> (unlk_q == LK_OPEN) && (page_q == page_chk_q) && !busy ##1 (unlk_q == LK_LOCKED) && busy;
  endproperty
  a_go: assert property (p_go) else $error("operation without unlock");
  property p_hold;
    @(posedge clk) disable iff (!rst_b) cpu_rst_hold |-> !op_go && !fl_prog && !fl_erase;
  endproperty
  a_hold: assert property (p_hold) else $error("operation during reset");
  property p_freq;
    @(posedge clk) disable iff (!rst_b)
      (wr_hi && !busy) |=> (flash_timing_freq_value[15:8] == $past(reg_wdata));
  endproperty
  a_freq: assert property (p_freq) else $error("frequency high byte lost");
  property p_opaque;
    @(posedge clk) disable iff (!rst_b) (reg_rd && (reg_addr > REG_STAT)) |=> (reg_rdata == 8'h00);
  endproperty
  a_opaque: assert property (p_opaque) else $error("unmapped read returned data");
endmodule

// [dv/flash_array_model.sv]
module flash_array_model import flash_opt_pkg::*; (
  // Clock
  input wire logic clk,
  // Read port
  input wire logic rd,
  input wire logic [15:0] addr,
  output logic [7:0] rdata,
  // Stored option bytes
  input wire logic [7:0] opt0,
  input wire logic [7:0] opt1
);
  timeunit 1ns;
  timeprecision 1ns;
  // Data one cycle after the strobe; toggles otherwise so stale bytes never pass
  always_ff @(posedge clk) begin
    if (rd) rdata <= (addr == OPT_ADDR1) ? opt1 : opt0;
    else rdata <= ~rdata;
  end
endmodule

// [dv/flash_timing_protect_options_tb.sv]
module flash_timing_protect_options_tb import flash_opt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, data_rd = 0, data_wr = 0, dbg_rd_req = 1, stop_recover = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, fo0 = 8'h5b, fo1 = 8'he1, c0, c1, rv, reg_rdata, fl_rdata, fl_wdata;
  logic [15:0] data_addr = 16'h0000, fl_addr;
  logic info_sel, data_wr_block, dbg_rd_grant, fl_rd, fl_info, fl_prog, fl_erase, cpu_rst_hold;
  logic wdt_irq_mode, wdt_run_at_reset, bo_on_in_stop;
  logic [1:0] osc_mode;
  logic [4:0] ipo_trim;
  logic [2:0] bo_trim;
  int miscompares = 0, check_count = 0, n;
  logic [15:0] wa[5] = '{16'hfe00, 16'hfe3f, 16'hfe40, 16'hfe7f, 16'hfe80};
  logic [7:0] o0s[3] = '{8'ha7, 8'ha5, 8'ha2};
  logic [7:0] o1s[3] = '{8'h69, 8'hc3, 8'h3c};
  int en[3] = '{400, 0, 0};

  // Short erase scale keeps the run brief
  flash_timing_protect_options #(.ERASE_MS(20'd1)) flash_timing_protect_options_inst (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr), .info_sel(info_sel),
    .data_wr_block(data_wr_block), .dbg_rd_req(dbg_rd_req), .dbg_rd_grant(dbg_rd_grant), .fl_rdata(fl_rdata),
    .fl_rd(fl_rd), .fl_addr(fl_addr), .fl_info(fl_info), .fl_wdata(fl_wdata), .fl_prog(fl_prog),
    .fl_erase(fl_erase), .stop_recover(stop_recover), .cpu_rst_hold(cpu_rst_hold), .wdt_irq_mode(wdt_irq_mode),
    .wdt_run_at_reset(wdt_run_at_reset), .bo_on_in_stop(bo_on_in_stop), .osc_mode(osc_mode),
    .ipo_trim(ipo_trim), .bo_trim(bo_trim));
  flash_array_model flash_array_model_inst (.clk(clk), .rd(fl_rd), .addr(fl_addr), .rdata(fl_rdata),
    .opt0(fo0), .opt1(fo1));

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // Loaded fields against the last bytes that a reset should have fetched
  task automatic cfg(string nm);
    #1 chk(nm, {3'h0, c0[7:3], c1}, {3'h0, wdt_irq_mode, ~wdt_run_at_reset, bo_on_in_stop, osc_mode, ipo_trim, bo_trim});
  endtask
  // Full unlock sequence, then count the pulse length
  task automatic op(logic [15:0] f, logic [7:0] pg, logic [7:0] cmd, int w);
    wr(REG_STAT, 8'h00);
    wr(REG_FREQ_HI, f[15:8]);
    wr(REG_FREQ_LO, f[7:0]);
    wr(REG_PAGE, pg);
    wr(REG_PAGE_CHK, pg);
    wr(REG_PADDR, 8'h15);
    wr(REG_PDATA, 8'h3c);
    wr(REG_CTL, UNLOCK_KEY1);
    wr(REG_CTL, UNLOCK_KEY2);
    wr(REG_CTL, cmd);
    n = 0;
    repeat (w) @(negedge clk) n += int'(fl_prog | fl_erase);
  endtask
  // New bytes in flash must wait for a recovery to take hold
  task automatic reload(logic [7:0] o0, logic [7:0] o1);
    fo0 <= o0;
    fo1 <= o1;
    repeat (4) @(posedge clk);
    stop_recover <= 1'b1;
    dbg_rd_req <= 1'b1;
    cfg("config before reload");
    repeat (20) @(posedge clk);
    stop_recover <= 1'b0;
    c0 = o0;
    c1 = o1;
    cfg("config after reload");
  endtask
  task automatic summarize;
    $display("Counts: %0d checks, %0d mismatches", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Clock and watchdog; the tests need under 25000 cycles, mostly the erase
  initial forever #25 clk = ~clk;
  initial begin
    #2000000;
    miscompares++;
    summarize;
  end
  initial begin
    c0 = fo0;
    c1 = fo1;
    repeat (3) @(posedge clk);
    chk("hold in reset", 16'h1, cpu_rst_hold);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 chk("hold after release", 16'h1, cpu_rst_hold);
    chk("option fetch strobe", 16'h1, fl_rd);
    repeat (12) @(posedge clk);
    cfg("config after reset");
    chk("hold released", 16'h0, cpu_rst_hold);
    $display("test reset load done");
    wr(REG_PAGE, 8'h80);
    foreach (wa[i]) begin
      @(posedge clk);
      data_wr <= 1'b0;
      data_addr <= wa[i];
      data_rd <= 1'b1;
      #1 chk("info select", 16'(i < 2), info_sel);
      @(posedge clk);
      data_rd <= 1'b0;
      data_wr <= 1'b1;
      #1 chk("data write block", 16'(i < 4), data_wr_block);
    end
    @(posedge clk);
    data_wr <= 1'b0;
    wr(REG_PAGE, 8'h00);
    data_addr <= 16'hfe00;
    data_rd <= 1'b1;
    #1 chk("info select closed", 16'h0, info_sel);
    @(posedge clk);
    data_rd <= 1'b0;
    $display("test data window done");
    for (int i = 0; i < 3; i++) begin
      reload(o0s[i], o1s[i]);
      chk("debug grant", 16'(o0s[i][2]), dbg_rd_grant);
      @(posedge clk);
      dbg_rd_req <= 1'b0;
      #1 chk("debug grant idle", 16'h0, dbg_rd_grant);
      op(16'h4e20, 8'h70, CMD_PROG, 450);
      chk("program cycles", 16'(en[i]), 16'(n));
      chk("flash address", (en[i] != 0) ? 16'h3815 : OPT_ADDR1, fl_addr);
      chk("flash write data", 16'h3c, 16'(fl_wdata));
      rd(REG_STAT);
      chk("refusal flag", 16'(en[i] == 0), 16'(rv[STAT_ERR]));
      $display("test protection level %0d done", i);
    end
    op(16'h4e20, 8'h80, CMD_ERASE, 20050);
    chk("erase cycles", 16'd20000, 16'(n));
    chk("erase on info page", 16'h1, fl_info);
    rd(REG_FREQ_LO);
    chk("frequency low byte", 16'h20, 16'(rv));
    rd(REG_FREQ_HI);
    chk("frequency high byte", 16'h4e, 16'(rv));
    rd(4'hf);
    chk("unmapped read", 16'h0, 16'(rv));
    $display("test erase and readback done");
    summarize;
  end
endmodule
